// ### design/eam_pkg.sv
// constants, types and helper functions of the exclusive access monitor
// assumes one bus clock, a synchronous active-high reset and a zero-wait memory slave
//
// Behaviour
// - exclusive write updates memory only if no other master wrote since the read
// - at least one reservation is tracked per exclusive-capable master at once
// - monitor sees every access to every location used for exclusive sequences
// - each thread carries its own id, made unique by the interconnect
// - id is 4 bits at interconnect master ports, 8 bits at monitor
// - exclusive okay high on success (write reached memory), low on failure
// - exclusive transfer to a region without exclusive support fails
// - exclusive okay only with ready high and never with an error response
// - read and write pair only if address, size, prot, burst, id, nonsec match
// - exclusive write without matching earlier exclusive read fails
// - an exclusive read never followed by a write is tolerated
// - exclusive address may overlap earlier exclusive data only with another id
// - exclusive address phase needs flag high and nonseq; idle is ignored
// - same-master plain write to reserved bytes keeps the reservation
// - inputs sampled on rising clock edge, outputs change after it
// - reset releases synchronously after a rising clock edge
package eam_pkg;

  localparam int ADDR_W = 32;
  localparam int ID_W = 8;
  localparam int SIZE_W = 3;
  localparam int PROT_W = 4;
  localparam int BURST_W = 3;
  localparam int NUM_ENTRIES = 16;
  localparam int IDX_W = 4;

  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] TRANS_BUSY = 2'h1;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ = 2'h3;
  localparam logic [BURST_W-1:0] BURST_SINGLE = 3'h0;
  localparam logic [BURST_W-1:0] BURST_INCR = 3'h1;

  localparam logic OKAY_RST = 1'b0;
  localparam logic READY_RST = 1'b1;
  localparam logic RESP_RST = 1'b0;
  localparam logic INHIBIT_RST = 1'b0;
  localparam logic [NUM_ENTRIES-1:0] VALID_RST = 16'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SIZE_W-1:0] size;
    logic [PROT_W-1:0] prot;
    logic [BURST_W-1:0] burst;
    logic nonsec;
  } eam_attr_t;

  // two size-aligned byte blocks overlap when they agree above the larger size
  function automatic logic eam_overlap(input logic [ADDR_W-1:0] a,
                                       input logic [SIZE_W-1:0] sa,
                                       input logic [ADDR_W-1:0] b,
                                       input logic [SIZE_W-1:0] sb);
    logic [SIZE_W-1:0] big;
    logic [ADDR_W-1:0] mask;
    big = (sa > sb) ? sa : sb;
    mask = ~((32'h0000_0001 << big) - 32'h0000_0001);
    return ((a & mask) == (b & mask));
  endfunction

  function automatic logic eam_aligned(input logic [ADDR_W-1:0] a,
                                       input logic [SIZE_W-1:0] s);
    return ((a & ((32'h0000_0001 << s) - 32'h0000_0001)) == 32'h0000_0000);
  endfunction

  function automatic logic eam_same_seq(input eam_attr_t a, input eam_attr_t b);
    return (a == b);
  endfunction

  function automatic logic eam_id_ok(input logic [ID_W-1:0] id);
    return (id < ID_W'(NUM_ENTRIES));
  endfunction

endpackage

// ### design/eam_resv_table.sv
// reservation table: one entry for each of master ids 0 to 15, with parallel snoop clearing
// assumes set, own-clear and snoop requests come from the monitor on the same clock
`timescale 1ns/100ps
module eam_resv_table
  import eam_pkg::*;
(
  input logic clk,
  input logic sys_rst,
  input logic setEn,
  input logic [IDX_W-1:0] setIdx,
  input eam_attr_t setAttr,
  input logic clrOwnEn,
  input logic [IDX_W-1:0] clrIdx,
  input logic snoopEn,
  input logic snoopIdOk,
  input logic [IDX_W-1:0] snoopIdx,
  input logic [ADDR_W-1:0] snoopAddr,
  input logic [SIZE_W-1:0] snoopSize,
  input logic [IDX_W-1:0] lookIdx,
  output logic lookValid,
  output eam_attr_t lookAttr
);

  // ----------------------------------------------------------------
  // entries
  // ----------------------------------------------------------------
  logic [NUM_ENTRIES-1:0] valid_r;
  eam_attr_t attr_r [NUM_ENTRIES];
  logic [NUM_ENTRIES-1:0] hitVec;

  always_comb begin
    for (int k = 0; k < NUM_ENTRIES; k++) begin
      hitVec[k] = snoopEn && valid_r[k] &&
                  (!snoopIdOk || (snoopIdx != IDX_W'(k))) &&
                  eam_overlap(attr_r[k].addr, attr_r[k].size, snoopAddr, snoopSize);
    end
  end

  // an entry left standing forever costs nothing but one slot
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valid_r <= VALID_RST;
    end else begin
      for (int k = 0; k < NUM_ENTRIES; k++) begin
        if (hitVec[k] || (clrOwnEn && (clrIdx == IDX_W'(k)))) begin
          valid_r[k] <= 1'b0;
        end
        if (setEn && (setIdx == IDX_W'(k))) begin
          valid_r[k] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int k = 0; k < NUM_ENTRIES; k++) begin
      if (setEn && (setIdx == IDX_W'(k))) begin
        attr_r[k] <= setAttr;
      end
    end
  end

  assign lookValid = valid_r[lookIdx];
  assign lookAttr = attr_r[lookIdx];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  foreign_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (hitVec != VALID_RST) |=> ((valid_r & $past(hitVec)) == VALID_RST))
    else $error("overlapping foreign write left a reservation standing");

  table_reset_a: assert property (@(posedge clk)
    $past(sys_rst) |-> (valid_r == VALID_RST))
    else $error("reservations survived reset");

  own_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    clrOwnEn |=> !valid_r[$past(clrIdx)])
    else $error("exclusive write left its own reservation standing");

endmodule

// ### design/eam_monitor.sv
// exclusive access monitor beside a zero-wait memory slave
// assumes bus inputs come from logic on clk and the memory honours memWrInhibit
`timescale 1ns/100ps
module eam_monitor
  import eam_pkg::*;
(
  input logic clk,
  input logic sys_rst,
  input logic hsel,
  input logic exclRegion,
  input logic hready,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [ADDR_W-1:0] haddr,
  input logic [SIZE_W-1:0] hsize,
  input logic [BURST_W-1:0] hburst,
  input logic [PROT_W-1:0] hprot,
  input logic hnonsec,
  input logic [ID_W-1:0] hmaster,
  input logic hexcl,
  output logic hexokay,
  output logic hreadyOut,
  output logic hresp,
  output logic memWrInhibit
);

  // ----------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------
  logic xferPhase;
  logic exclPhase;
  logic exclRd;
  logic exclWr;
  logic shapeOk;
  logic idOk;
  logic [IDX_W-1:0] idx;
  eam_attr_t curAttr;
  logic lookValid;
  eam_attr_t lookAttr;
  logic seqMatch;
  logic rdGrant;
  logic wrPass;
  logic wrFail;
  logic memWrite;

  // every transfer into this region is seen, exclusive or not
  assign xferPhase = hsel && hready &&
                     ((htrans == TRANS_NONSEQ) || (htrans == TRANS_SEQ));
  assign exclPhase = xferPhase && hexcl && (htrans == TRANS_NONSEQ);
  assign exclRd = exclPhase && !hwrite;
  assign exclWr = exclPhase && hwrite;

  // malformed exclusive shapes are failed rather than trusted
  assign shapeOk = ((hburst == BURST_SINGLE) || (hburst == BURST_INCR)) &&
                   eam_aligned(haddr, hsize);

  // ids beyond the table fail safely instead of aliasing another master
  assign idOk = eam_id_ok(hmaster);
  assign idx = hmaster[IDX_W-1:0];

  assign curAttr.addr = haddr;
  assign curAttr.size = hsize;
  assign curAttr.prot = hprot;
  assign curAttr.burst = hburst;
  assign curAttr.nonsec = hnonsec;

  assign seqMatch = lookValid && eam_same_seq(lookAttr, curAttr);
  assign rdGrant = exclRd && exclRegion && idOk && shapeOk;
  assign wrPass = exclWr && exclRegion && idOk && shapeOk && seqMatch;
  assign wrFail = exclWr && !wrPass;
  assign memWrite = xferPhase && hwrite && !wrFail;

  // ----------------------------------------------------------------
  // reservations
  // ----------------------------------------------------------------
  eam_resv_table u_table (
    .clk(clk),
    .sys_rst(sys_rst),
    .setEn(rdGrant),
    .setIdx(idx),
    .setAttr(curAttr),
    .clrOwnEn(exclWr && idOk),
    .clrIdx(idx),
    .snoopEn(memWrite),
    .snoopIdOk(idOk),
    .snoopIdx(idx),
    .snoopAddr(haddr),
    .snoopSize(hsize),
    .lookIdx(idx),
    .lookValid(lookValid),
    .lookAttr(lookAttr)
  );

  // ----------------------------------------------------------------
  // data phase response
  // ----------------------------------------------------------------
  logic hexokay_r;
  logic hexokay_nxt;
  logic hreadyOut_r;
  logic hresp_r;
  logic memWrInhibit_r;
  logic memWrInhibit_nxt;

  assign hexokay_nxt = rdGrant || wrPass;
  assign memWrInhibit_nxt = wrFail;

  // each exclusive address phase gets its own data-phase answer, so back-to-back
  // exclusive phases from different ids need no extra state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hexokay_r <= OKAY_RST;
    end else begin
      hexokay_r <= hexokay_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      memWrInhibit_r <= INHIBIT_RST;
    end else begin
      memWrInhibit_r <= memWrInhibit_nxt;
    end
  end

  // zero-wait region: the data phase always completes with an okay response
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyOut_r <= READY_RST;
      hresp_r <= RESP_RST;
    end else begin
      hreadyOut_r <= READY_RST;
      hresp_r <= RESP_RST;
    end
  end

  assign hexokay = hexokay_r;
  assign hreadyOut = hreadyOut_r;
  assign hresp = hresp_r;
  assign memWrInhibit = memWrInhibit_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seqGrantRd;
    exclRd && exclRegion && idOk && shapeOk;
  endsequence

  sequence seqOkAnswer;
    hexokay_r && hreadyOut_r && !hresp_r && !memWrInhibit_r;
  endsequence

  property propGrant;
    @(posedge clk) disable iff (sys_rst) seqGrantRd |=> seqOkAnswer;
  endproperty

  read_grant_a: assert property (propGrant)
    else $error("granted exclusive read not answered okay");

  okay_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
    hexokay_r |-> $past(exclPhase && exclRegion && idOk))
    else $error("exclusive okay without an exclusive phase");

  unsupported_fail_a: assert property (@(posedge clk) disable iff (sys_rst)
    (exclPhase && !exclRegion) |=> (!hexokay_r && (memWrInhibit_r == $past(hwrite))))
    else $error("exclusive to unsupported region not failed");

  okay_response_a: assert property (@(posedge clk) disable iff (sys_rst)
    hexokay_r |-> (hreadyOut_r && !hresp_r))
    else $error("exclusive okay outside a clean ready cycle");

  idle_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
    (hexcl && (htrans == TRANS_IDLE)) |=> (!hexokay_r && !memWrInhibit_r))
    else $error("idle with exclusive flag treated as exclusive");

  no_prior_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (exclWr && !lookValid) |=> (!hexokay_r && memWrInhibit_r))
    else $error("unreserved exclusive write not failed");

  sequence seqPairedWr;
    exclWr && exclRegion && idOk && shapeOk && seqMatch;
  endsequence

  paired_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    seqPairedWr |=> (hexokay_r && !memWrInhibit_r))
    else $error("matching exclusive write not passed");

  sequence seqQuietAnswer;
    !hexokay_r && !memWrInhibit_r;
  endsequence

  plain_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    (xferPhase && !exclPhase) |=> seqQuietAnswer)
    else $error("plain transfer given an exclusive answer");

  stall_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
    (hsel && !hready) |=> seqQuietAnswer)
    else $error("address phase taken while ready low");

  shape_fail_a: assert property (@(posedge clk) disable iff (sys_rst)
    (exclPhase && !shapeOk) |=> !hexokay_r)
    else $error("malformed exclusive transfer not failed");

  id_fail_a: assert property (@(posedge clk) disable iff (sys_rst)
    (exclPhase && !idOk) |=> !hexokay_r)
    else $error("exclusive with out-of-table id not failed");

  write_fail_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrFail |=> (!hexokay_r && memWrInhibit_r))
    else $error("failed exclusive write reached memory");

  read_no_inhibit_a: assert property (@(posedge clk) disable iff (sys_rst)
    exclRd |=> !memWrInhibit_r)
    else $error("exclusive read raised the write inhibit");

  inhibit_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
    memWrInhibit_r |-> ($past(exclWr) && !hexokay_r))
    else $error("memory write blocked without a failed exclusive write");

  reset_quiet_a: assert property (@(posedge clk)
    sys_rst |=> (!hexokay_r && !memWrInhibit_r && hreadyOut_r && !hresp_r))
    else $error("outputs not at rest after reset");

endmodule

// ### verif/eam_master_model.sv
// bus master and interconnect model: issues one transfer at a time to the monitor
// assumes its tasks are called just after a falling clock edge
`timescale 1ns/100ps
module eam_master_model
  import eam_pkg::*;
(
  input logic clk,
  input logic hexokay,
  input logic memWrInhibit,
  output logic hsel,
  output logic hready,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [ADDR_W-1:0] haddr,
  output logic [SIZE_W-1:0] hsize,
  output logic [BURST_W-1:0] hburst,
  output logic [PROT_W-1:0] hprot,
  output logic hnonsec,
  output logic [ID_W-1:0] hmaster,
  output logic hexcl
);
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  logic lastEx = 1'b0;
  logic [ID_W-1:0] lastId = 8'h00;

  initial begin
    hsel = 1'b0;
    hready = 1'b1;
    htrans = TRANS_IDLE;
    hwrite = 1'b0;
    {haddr, hsize, hprot, hburst, hnonsec} = 43'h0;
    hmaster = 8'h00;
    hexcl = 1'b0;
  end

  // released lines change pattern, never keep the last value
  task automatic idle();
    hsel = 1'b0;
    hready = 1'b1;
    htrans = TRANS_IDLE;
    hexcl = 1'b0;
    lastEx = 1'b0;
    hwrite = ~hwrite;
    {haddr, hsize, hprot, hburst, hnonsec} = ~{haddr, hsize, hprot, hburst, hnonsec};
    hmaster = ~hmaster;
  endtask

  // drives one address phase, returns the data phase answer
  task automatic xfer(input logic wr, input logic ex, input logic [1:0] tr,
                      input logic [ID_W-1:0] id, input eam_attr_t at,
                      output logic ok, output logic inh, input logic rdy = 1'b1);
    // a second exclusive of one id waits out the data phase of the first
    if (ex && (tr == TRANS_NONSEQ) && lastEx && (lastId == id)) begin
      idle();
      @(negedge clk);
    end
    hsel = 1'b1;
    hready = rdy;
    htrans = tr;
    hwrite = wr;
    hexcl = ex;
    hmaster = id;
    {haddr, hsize, hprot, hburst, hnonsec} = at;
    lastEx = ex && (tr == TRANS_NONSEQ) && rdy;
    lastId = id;
    @(posedge clk);
    @(negedge clk);
    ok = hexokay;
    inh = memWrInhibit;
  endtask
endmodule

// ### verif/tb.sv
// self-checking bench of the exclusive access monitor
// assumes the master model and the design package are compiled first
`timescale 1ns/100ps
module tb
  import eam_pkg::*;
;
  logic clk, sysRst, exclRegion, hsel, hready, hwrite, hnonsec, hexcl;
  logic hexokay, hreadyOut, hresp, memWrInhibit;
  logic [1:0] htrans;
  logic [ADDR_W-1:0] haddr;
  logic [SIZE_W-1:0] hsize;
  logic [BURST_W-1:0] hburst;
  logic [PROT_W-1:0] hprot;
  logic [ID_W-1:0] hmaster;
  int failures = 0;
  int cmpCount = 0;

  eam_monitor dut (.clk(clk), .sys_rst(sysRst), .hsel(hsel), .exclRegion(exclRegion),
    .hready(hready), .htrans(htrans), .hwrite(hwrite), .haddr(haddr), .hsize(hsize),
    .hburst(hburst), .hprot(hprot), .hnonsec(hnonsec), .hmaster(hmaster), .hexcl(hexcl),
    .hexokay(hexokay), .hreadyOut(hreadyOut), .hresp(hresp), .memWrInhibit(memWrInhibit));
  eam_master_model mst (.clk(clk), .hexokay(hexokay), .memWrInhibit(memWrInhibit),
    .hsel(hsel), .hready(hready), .htrans(htrans), .hwrite(hwrite), .haddr(haddr),
    .hsize(hsize), .hburst(hburst), .hprot(hprot), .hnonsec(hnonsec), .hmaster(hmaster),
    .hexcl(hexcl));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (failures == 0 && cmpCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // non-cacheable word access unless told otherwise
  function automatic eam_attr_t att(input logic [ADDR_W-1:0] a, input logic [2:0] s = 3'h2,
      input logic [3:0] p = 4'h3, input logic [2:0] b = BURST_SINGLE, input logic n = 1'b0);
    return '{a, s, p, b, n};
  endfunction

  task automatic ex(input logic wr, input logic [ID_W-1:0] id, input eam_attr_t at,
                    input logic expOk);
    logic ok, inh;
    mst.xfer(wr, 1'b1, TRANS_NONSEQ, id, at, ok, inh);
    chk("hexokay", ok, expOk);
    chk("memWrInhibit", inh, wr & ~expOk);
  endtask

  task automatic pl(input logic wr, input logic [ID_W-1:0] id, input eam_attr_t at);
    logic ok, inh;
    mst.xfer(wr, 1'b0, TRANS_NONSEQ, id, at, ok, inh);
    chk("plainAnswer", {ok, inh}, 2'h0);
  endtask

  task automatic rest();
    mst.idle();
    @(negedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_pass();
    ex(1'b0, 8'h03, att(32'h100), 1'b1);
    pl(1'b0, 8'h04, att(32'h100));
    ex(1'b1, 8'h03, att(32'h100), 1'b1);
    ex(1'b1, 8'h03, att(32'h100), 1'b0);
    rest();
  endtask

  task automatic s_steal();
    ex(1'b0, 8'h03, att(32'h200), 1'b1);
    ex(1'b0, 8'h04, att(32'h200), 1'b1);
    pl(1'b1, 8'h05, att(32'h202, 3'h1));
    ex(1'b1, 8'h03, att(32'h200), 1'b0);
    ex(1'b1, 8'h04, att(32'h200), 1'b0);
    ex(1'b0, 8'h03, att(32'h200), 1'b1);
    ex(1'b0, 8'h04, att(32'h200), 1'b1);
    ex(1'b1, 8'h04, att(32'h200), 1'b1);
    ex(1'b1, 8'h03, att(32'h200), 1'b0);
    ex(1'b0, 8'h06, att(32'h20c), 1'b1);
    pl(1'b1, 8'h05, att(32'h208));
    ex(1'b1, 8'h06, att(32'h20c), 1'b1);
    ex(1'b0, 8'h07, att(32'h400), 1'b1);
    pl(1'b1, 8'h07, att(32'h400));
    ex(1'b1, 8'h07, att(32'h400), 1'b1);
    rest();
  endtask

  task automatic s_all();
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      ex(1'b0, ID_W'(i), att(32'h1000 + 32'(i * 4)), 1'b1);
    end
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      ex(1'b1, ID_W'(i), att(32'h1000 + 32'(i * 4)), 1'b1);
    end
    rest();
  endtask

  task automatic s_attr();
    eam_attr_t v[5];
    v[0] = att(32'h504);
    v[1] = att(32'h500, 3'h1);
    v[2] = att(32'h500, 3'h2, 4'h1);
    v[3] = att(32'h500, 3'h2, 4'h3, BURST_INCR);
    v[4] = att(32'h500, 3'h2, 4'h3, BURST_SINGLE, 1'b1);
    foreach (v[k]) begin
      ex(1'b0, 8'h08, att(32'h500), 1'b1);
      ex(1'b1, 8'h08, v[k], 1'b0);
    end
    ex(1'b0, 8'h08, v[3], 1'b1);
    ex(1'b1, 8'h08, v[3], 1'b1);
    rest();
  endtask

  task automatic s_refuse();
    logic ok, inh;
    exclRegion = 1'b0;
    ex(1'b0, 8'h09, att(32'h600), 1'b0);
    exclRegion = 1'b1;
    ex(1'b0, 8'h09, att(32'h602), 1'b0);
    ex(1'b0, 8'h09, att(32'h600, 3'h2, 4'h3, 3'h2), 1'b0);
    mst.xfer(1'b0, 1'b1, TRANS_IDLE, 8'h09, att(32'h600), ok, inh);
    chk("hexokay", ok, 1'b0);
    mst.xfer(1'b0, 1'b1, TRANS_NONSEQ, 8'h09, att(32'h600), ok, inh, 1'b0);
    chk("stalledOkay", ok, 1'b0);
    chk("stalledInhibit", inh, 1'b0);
    ex(1'b0, 8'h19, att(32'h600), 1'b0);
    ex(1'b1, 8'h09, att(32'h600), 1'b0);
    ex(1'b0, 8'h09, att(32'h600), 1'b1);
    ex(1'b0, 8'h09, att(32'h608), 1'b1);
    ex(1'b1, 8'h09, att(32'h608), 1'b1);
    rest();
  endtask

  task automatic s_reset();
    ex(1'b0, 8'h02, att(32'h800), 1'b1);
    rest();
    sysRst = 1'b1;
    repeat (2) @(negedge clk);
    chk("hexokay", hexokay, 1'b0);
    chk("hreadyOut", hreadyOut, 1'b1);
    chk("hresp", hresp, 1'b0);
    sysRst = 1'b0;
    ex(1'b1, 8'h02, att(32'h800), 1'b0);
    rest();
  endtask

  initial begin
    sysRst = 1'b1;
    exclRegion = 1'b1;
    repeat (12) @(negedge clk);
    sysRst = 1'b0;
    chk("hexokay", hexokay, 1'b0);
    s_pass();
    s_steal();
    s_all();
    s_attr();
    s_refuse();
    s_reset();
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
